// [logic/mpwm_pkg.sv]
package mpwm_pkg;
  // Channel count and internal duty/period width.
  localparam int NCH = 8;
  localparam int DW = 11;
  localparam int AW = 12;
  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL0 = 8'h00;
  localparam logic [7:0] IDX_CTRL1 = 8'h01;
  localparam logic [7:0] IDX_PER = 8'h02;
  localparam logic [7:0] IDX_CC0 = 8'h10;
  localparam logic [7:0] IDX_CC7 = 8'h17;
  localparam logic [7:0] IDX_DC0 = 8'h20;
  localparam logic [7:0] IDX_DC7 = 8'h27;
  // Field positions.
  localparam int PRE_LSB = 5;
  localparam int FAST_BIT = 3;
  localparam int DITHER_ENABLE_BIT = 2;
  localparam int RECIRCULATION_SIDE_BIT = 7;
  localparam int OM_LSB = 6;
  localparam int AM_LSB = 4;
  localparam int CD_LSB = 0;
  localparam int SIGN_BIT = 15;
  localparam int FDUTY_LSB = 8;
  localparam int FDUTY_W = 7;
  localparam int FDUTY_SH = 2;
  // Prescaler terminal counts for divide by 1, 2, 4 and 8.
  localparam logic [2:0] PRE_MASK [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  typedef enum logic [1:0] {
    OM_HALF_M,
    OM_HALF_P,
    OM_FULL,
    OM_DUAL
  } omode_t;

  typedef enum logic [1:0] {
    AM_OFF,
    AM_LEFT,
    AM_RIGHT,
    AM_CENTER
  } amode_t;

  typedef struct packed {
    omode_t om;
    amode_t am;
    logic [1:0] cd;
  } cc_t;

  typedef struct packed {
    logic minus_out;
    logic minus_oe;
    logic plus_out;
    logic plus_oe;
  } pin_t;
endpackage

// [logic/motor_pwm_core.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Each period lasts the period count of prescaled timer clocks.
// - With dither, period bit 0 is ignored, reads zero; period is 2*D[10:1].
// - Period zero disables all channels after next overflow, pins released.
// - Period one with dither behaves as period zero.
// - Eight channel control registers, one per channel, consecutive.
// - Output mode bits 7:6: half minus, half plus, full, dual full.
// - Alignment bits 5:4: disabled, left, right, center.
// - Mode and alignment buffered; copied at once if all off or period zero, else at overflow.
// - Control and duty reads return last written values.
// - Delay bits 1:0 delay the output by that many timer clocks.
// - Disabling releases pins after next overflow without any delay.
// - Duty counts clocks driven low (high-side) or high (low-side).
// - Duty zero gives static high (high-side) or low (low-side).
// - Duty at or above period gives the opposite static level.
// - In fast mode duty writes clear the two top and bottom bits.
// - Resolution only changes register layout, not stored duty.
// - Sign and duty buffered; copied on zero period, off, or overflow.
// - Dual pair loads duty at overflow only after odd register write.
// - Sign picks the pwm pin in full modes, ignored in half modes.
// - Resolution bit clear gives 11-bit words, set gives 7-bit bytes.
// - Prescaler divides by 1, 2, 4, 8; change applies next period.
// - Dither bit enables dither when set.
module motor_pwm_core
  import mpwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pin_t [NCH-1:0] pins
);

  logic rs1_q;
  logic rst_ok_q;
  logic [1:0] pre_q;
  logic fast_q;
  logic dither_enable_q;
  logic recirculation_side_q;
  logic [DW-1:0] per_q;
  cc_t cc_q [NCH];
  logic [DW-1:0] duty_q [NCH];
  logic [NCH-1:0] sign_q;
  logic [NCH/2-1:0] pend_q;
  logic [7:0] idx;
  logic [2:0] ch;
  logic is_cc;
  logic is_dc;
  logic hit;
  logic wr;
  logic rvalid_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic [DW-1:0] per_eff;
  logic per_zero;
  logic [2:0] pcnt_q;
  logic [1:0] pre_w_q;
  logic tick;
  logic [DW-1:0] cnt_q;
  logic ovf;
  logic pz_q;
  omode_t wom_q [NCH];
  amode_t wam_q [NCH];
  logic [NCH-1:0] en;
  logic all_off;

  // Reset is released through two flops so all state leaves reset together.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rst_ok_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_ok_q <= rs1_q;
    end
  end

  // Address decode; unmapped or misaligned addresses answer with an error.
  assign idx = paddr[9:2];
  assign ch = idx[2:0];
  assign is_cc = idx >= IDX_CC0 && idx <= IDX_CC7;
  assign is_dc = idx >= IDX_DC0 && idx <= IDX_DC7;
  assign hit = paddr[1:0] == '0 && paddr[AW-1:10] == '0 &&
    (idx == IDX_CTRL0 || idx == IDX_CTRL1 || idx == IDX_PER || is_cc ||
     is_dc);
  assign pready = ce && psel && penable && rvalid_q;
  assign pslverr = pready && !hit;
  assign wr = pready && pwrite && hit;
  assign prdata = prdata_q;

  // Read data is captured before the access edge, so a frozen clock
  // enable simply adds wait states instead of returning stale data.
  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      rvalid_q <= 1'b0;
      prdata_q <= '0;
    end else if (ce) begin
      rvalid_q <= psel && !pready;
      if (psel) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // Read multiplexer; stored values come back, not the working copies.
  always_comb begin
    rdata_d = '0;
    if (hit) begin
      if (idx == IDX_CTRL0) begin
        rdata_d[PRE_LSB+:2] = pre_q;
        rdata_d[FAST_BIT] = fast_q;
        rdata_d[DITHER_ENABLE_BIT] = dither_enable_q;
      end else if (idx == IDX_CTRL1) begin
        rdata_d[RECIRCULATION_SIDE_BIT] = recirculation_side_q;
      end else if (idx == IDX_PER) begin
        rdata_d[DW-1:0] = per_q;
        rdata_d[0] = per_q[0] && !dither_enable_q;
      end else if (is_cc) begin
        rdata_d[OM_LSB+:2] = cc_q[ch].om;
        rdata_d[AM_LSB+:2] = cc_q[ch].am;
        rdata_d[CD_LSB+:2] = cc_q[ch].cd;
      end else begin
        rdata_d[SIGN_BIT] = sign_q[ch];
        if (fast_q) begin
          rdata_d[FDUTY_LSB+:FDUTY_W] =
            duty_q[ch][FDUTY_SH+:FDUTY_W];
        end else begin
          rdata_d[DW-1:0] = duty_q[ch];
        end
      end
    end
  end

  // Global control and period registers.
  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      pre_q <= '0;
      fast_q <= 1'b0;
      dither_enable_q <= 1'b0;
      recirculation_side_q <= 1'b0;
      per_q <= '0;
    end else if (wr) begin
      if (idx == IDX_CTRL0) begin
        pre_q <= pwdata[PRE_LSB+:2];
        fast_q <= pwdata[FAST_BIT];
        dither_enable_q <= pwdata[DITHER_ENABLE_BIT];
      end
      if (idx == IDX_CTRL1) begin
        recirculation_side_q <= pwdata[RECIRCULATION_SIDE_BIT];
      end
      if (idx == IDX_PER) begin
        per_q <= pwdata[DW-1:0];
      end
    end
  end

  // Channel control and duty registers. In fast mode only the high byte
  // carries duty, so the bits it cannot reach are forced to zero.
  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      cc_q <= '{default: '0};
      duty_q <= '{default: '0};
      sign_q <= '0;
    end else if (wr) begin
      if (is_cc) begin
        cc_q[ch] <= cc_t'({pwdata[OM_LSB+:2], pwdata[AM_LSB+:2],
                           pwdata[CD_LSB+:2]});
      end
      if (is_dc) begin
        sign_q[ch] <= pwdata[SIGN_BIT];
        if (fast_q) begin
          duty_q[ch] <= {2'h0, pwdata[FDUTY_LSB+:FDUTY_W], 2'h0};
        end else begin
          duty_q[ch] <= pwdata[DW-1:0];
        end
      end
    end
  end

  // A write to the odd register of a pair arms its dual-mode update; a
  // write landing on the overflow cycle re-arms so it is not lost.
  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      pend_q <= '0;
    end else if (ce) begin
      for (int p = 0; p < NCH / 2; p++) begin
        if (wr && is_dc && ch[2:1] == 2'(p) && ch[0]) begin
          pend_q[p] <= 1'b1;
        end else if (ovf) begin
          pend_q[p] <= 1'b0;
        end
      end
    end
  end

  // Effective period; dither with period one collapses to zero.
  assign per_eff = dither_enable_q ? {per_q[DW-1:1], 1'b0} : per_q;
  assign per_zero = per_eff == '0;

  // Prescaler and timer counter. The divider in use is only swapped at an
  // overflow, so a period never mixes two timer clock rates.
  assign tick = pcnt_q == PRE_MASK[pre_w_q];
  assign ovf = tick && (per_zero || cnt_q >= per_eff - 1'b1);

  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      pcnt_q <= '0;
      pre_w_q <= '0;
      cnt_q <= '0;
      pz_q <= 1'b1;
    end else if (ce) begin
      pcnt_q <= tick ? '0 : pcnt_q + 1'b1;
      if (ovf) begin
        cnt_q <= '0;
        pre_w_q <= pre_q;
        pz_q <= per_zero;
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Working mode and alignment: copied at once while nothing runs or the
  // period is zero, otherwise only on the period boundary.
  assign all_off = en == '0;

  always_ff @(posedge clock or negedge rst_ok_q) begin
    if (!rst_ok_q) begin
      wom_q <= '{default: OM_HALF_M};
      wam_q <= '{default: AM_OFF};
    end else if (ce && (all_off || per_zero || ovf)) begin
      for (int k = 0; k < NCH; k++) begin
        wom_q[k] <= cc_q[k].om;
        wam_q[k] <= cc_q[k].am;
      end
    end
  end

  sequence s_ovf;
    ce && ovf;
  endsequence

  property p_ovf_wrap;
    @(posedge clock) disable iff (!rst_ok_q)
    s_ovf |=> cnt_q == '0;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap)
    else $error("Counter did not wrap after overflow.");

  property p_count_step;
    @(posedge clock) disable iff (!rst_ok_q)
    (ce && tick && !ovf) |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Counter did not advance on a timer tick.");

  property p_dither_enable_read;
    @(posedge clock) disable iff (!rst_ok_q)
    (ce && psel && !penable && idx == IDX_PER && dither_enable_q)
      |=> prdata_q[0] == 1'b0;
  endproperty
  a_dither_enable_read: assert property (p_dither_enable_read)
    else $error("Period bit 0 read as one with dither on.");

  property p_zero_off;
    @(posedge clock) disable iff (!rst_ok_q)
    s_ovf ##0 per_zero |=> en == '0;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("Channels still enabled after zero period overflow.");

  property p_fast_wr;
    @(posedge clock) disable iff (!rst_ok_q)
    (wr && is_dc && fast_q) |=>
      duty_q[$past(ch)][1:0] == '0 && duty_q[$past(ch)][DW-1:DW-2] == '0;
  endproperty
  a_fast_wr: assert property (p_fast_wr)
    else $error("Fast duty write left edge bits set.");

  // The working copy picks up a write one cycle after it lands.
  property p_imm_copy;
    @(posedge clock) disable iff (!rst_ok_q)
    (ce && all_off && !pz_q && wr && is_cc) ##1 ce |=>
      wam_q[$past(ch, 2)] == cc_q[$past(ch, 2)].am;
  endproperty
  a_imm_copy: assert property (p_imm_copy)
    else $error("Alignment not copied at once while all channels off.");

  // Per-channel working duty, waveform, delay line and pin drive.
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic dual;
    logic load;
    logic [DW-1:0] wduty_q;
    logic wsign_q;
    logic [DW-1:0] lo;
    logic act;
    logic lvl;
    logic dl;
    logic [2:0] dly_q;
    logic on_plus;
    pin_t pin_d;

    assign en[k] = wam_q[k] != AM_OFF && !pz_q;
    assign dual = wom_q[k] == OM_DUAL && wom_q[k ^ 1] == OM_DUAL &&
      en[k] && en[k ^ 1];
    assign load = per_zero || cc_q[k].am == AM_OFF ||
      (ovf && (!dual || pend_q[k / 2]));

    always_ff @(posedge clock or negedge rst_ok_q) begin
      if (!rst_ok_q) begin
        wduty_q <= '0;
        wsign_q <= 1'b0;
      end else if (ce && load) begin
        wduty_q <= duty_q[k];
        wsign_q <= sign_q[k];
      end
    end

    // Active window of the waveform. Zero duty is tested first, since the
    // counter may still sit above a shortened period until it wraps.
    assign lo = DW'((per_eff - wduty_q) >> 1);
    always_comb begin
      act = 1'b0;
      if (wduty_q == '0) begin
        act = 1'b0;
      end else if (wduty_q >= per_eff) begin
        act = 1'b1;
      end else begin
        case (wam_q[k])
          AM_LEFT: act = cnt_q < wduty_q;
          AM_RIGHT: act = cnt_q >= per_eff - wduty_q;
          AM_CENTER: act = cnt_q >= lo && cnt_q < lo + wduty_q;
          default: act = 1'b0;
        endcase
      end
    end

    // Half bridges always pwm active low; full bridges follow the
    // recirculation side.
    assign lvl = (wom_q[k] == OM_HALF_M || wom_q[k] == OM_HALF_P) ?
      !act : (act ? recirculation_side_q : !recirculation_side_q);

    // Delay line stepped by timer ticks, tapped by the delay field.
    always_ff @(posedge clock or negedge rst_ok_q) begin
      if (!rst_ok_q) begin
        dly_q <= '0;
      end else if (ce && tick) begin
        dly_q <= {dly_q[1:0], lvl};
      end
    end
    assign dl = cc_q[k].cd == '0 ? lvl : dly_q[cc_q[k].cd - 2'h1];

    // Pin drive; a disabled channel releases both pins undelayed.
    assign on_plus = wsign_q ^ recirculation_side_q;
    always_comb begin
      pin_d = '0;
      if (en[k]) begin
        case (wom_q[k])
          OM_HALF_M: begin
            pin_d.minus_out = dl;
            pin_d.minus_oe = 1'b1;
          end
          OM_HALF_P: begin
            pin_d.plus_out = dl;
            pin_d.plus_oe = 1'b1;
          end
          default: begin
            pin_d.plus_out = on_plus ? dl : !recirculation_side_q;
            pin_d.minus_out = on_plus ? !recirculation_side_q : dl;
            pin_d.plus_oe = 1'b1;
            pin_d.minus_oe = 1'b1;
          end
        endcase
      end
    end

    always_ff @(posedge clock or negedge rst_ok_q) begin
      if (!rst_ok_q) begin
        pins[k] <= '0;
      end else if (ce) begin
        pins[k] <= pin_d;
      end
    end

    property p_zero_duty;
      @(posedge clock) disable iff (!rst_ok_q)
      (wduty_q == '0 && !per_zero) |-> !act;
    endproperty
    a_zero_duty: assert property (p_zero_duty)
      else $error("Zero duty produced an active window.");

    property p_full_duty;
      @(posedge clock) disable iff (!rst_ok_q)
      (wduty_q >= per_eff && !per_zero) |-> act;
    endproperty
    a_full_duty: assert property (p_full_duty)
      else $error("Full duty did not give a static level.");

    property p_dual_hold;
      @(posedge clock) disable iff (!rst_ok_q)
      (s_ovf ##0 dual && !pend_q[k / 2] && !per_zero &&
       cc_q[k].am != AM_OFF) |=> wduty_q == $past(wduty_q);
    endproperty
    a_dual_hold: assert property (p_dual_hold)
      else $error("Dual pair duty loaded without an odd write.");
  end

endmodule

// [verification/coil_drive_model.sv]
`timescale 1ns/1ps
// Coil side of the bridges; a released pin floats, so its level keeps moving.
module coil_drive_model
  import mpwm_pkg::*;
(
  input wire logic clock,
  input wire pin_t [NCH-1:0] pins,
  output logic [NCH-1:0] coil_m,
  output logic [NCH-1:0] coil_p
);
  logic [NCH-1:0] last_m = '0;
  logic [NCH-1:0] last_p = '0;

  // Inverting the last level stops a stuck enable from passing unseen.
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      coil_m[k] = pins[k].minus_oe ? pins[k].minus_out : ~last_m[k];
      coil_p[k] = pins[k].plus_oe ? pins[k].plus_out : ~last_p[k];
    end
  end

  // Remember the level of each node for the next cycle.
  always_ff @(posedge clock) begin
    last_m <= coil_m;
    last_p <= coil_p;
  end
endmodule

// [verification/motor_pwm_period_channel_duty_tb.sv]
`timescale 1ns/1ps
module motor_pwm_period_channel_duty_tb
  import mpwm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pin_t [NCH-1:0] pins;
  logic [NCH-1:0] coil_m;
  logic [NCH-1:0] coil_p;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [15:0] m_reg [64];
  logic [7:0] seed = 8'h4A;
  // Cases: mode, alignment, recirculation, sign, prescaler, period, duty.
  int t_om [7] = '{0, 1, 2, 2, 3, 0, 2};
  int t_am [7] = '{1, 2, 3, 1, 1, 1, 2};
  int t_rc [7] = '{0, 1, 0, 1, 1, 0, 0};
  int t_sg [7] = '{0, 0, 1, 0, 1, 0, 0};
  int t_pre [7] = '{0, 1, 2, 3, 0, 0, 0};
  int t_per [7] = '{10, 10, 6, 5, 12, 8, 15};
  int t_dty [7] = '{3, 4, 2, 1, 0, 8, 20};

  // Free-running 250 MHz clock.
  always #2 clock = ~clock;

  motor_pwm_core motor_pwm_core_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins)
  );

  coil_drive_model coil_drive_model_inst (
    .clock(clock), .pins(pins), .coil_m(coil_m), .coil_p(coil_p)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    return i <= IDX_PER || (i >= IDX_CC0 && i <= IDX_CC7) ||
      (i >= IDX_DC0 && i <= IDX_DC7);
  endfunction

  // Read view of the shadow registers, as software should see them.
  function automatic logic [31:0] exp_rd(input logic [7:0] i);
    logic [15:0] r;
    r = m_reg[i[5:0]];
    if (!mapped(i)) return 32'h0;
    if (i == IDX_PER && m_reg[0][DITHER_ENABLE_BIT]) return {16'h0, r & 16'h07FE};
    if (i >= IDX_DC0 && m_reg[0][FAST_BIT]) return {16'h0, r[15], r[8:2], 8'h00};
    return {16'h0, r};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel never toggles twice.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Write through the bus and update the shadow copy alongside.
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [31:0] v;
    logic err;
    apb(1'b1, i, {16'h0, d}, v, err);
    check("write error", {31'h0, err}, {31'h0, !mapped(i)});
    if (i == IDX_CTRL0) m_reg[0] = d & 16'h006C;
    else if (i == IDX_CTRL1) m_reg[1] = d & 16'h0080;
    else if (i == IDX_PER) m_reg[2] = d & 16'h07FF;
    else if (i >= IDX_CC0 && i <= IDX_CC7) m_reg[i[5:0]] = d & 16'h00F3;
    else if (mapped(i) && m_reg[0][FAST_BIT]) m_reg[i[5:0]] = {d[15], 6'h0, d[14:8], 2'h0};
    else if (mapped(i)) m_reg[i[5:0]] = d & 16'h87FF;
  endtask

  task automatic rd(input logic [7:0] i);
    logic [31:0] v;
    logic err;
    apb(1'b0, i, 32'h0, v, err);
    check("read data", v, exp_rd(i));
    check("read error", {31'h0, err}, {31'h0, !mapped(i)});
  endtask

  // Counts active cycles and their starts on channel ch over 120 clocks.
  task automatic measure(input int ch, input logic act, output int hits,
                         output int edges, output logic [1:0] oe);
    logic prev;
    logic now;
    hits = 0;
    edges = 0;
    oe = 2'b11;
    prev = 1'b0;
    for (int s = 0; s <= 120; s++) begin
      @(posedge clock);
      now = (pins[ch].minus_oe && coil_m[ch] == act) ||
        (pins[ch].plus_oe && coil_p[ch] == act);
      oe = oe & {pins[ch].minus_oe, pins[ch].plus_oe};
      if (s > 0 && now && !prev) edges++;
      if (s > 0) hits += int'(now);
      prev = now;
    end
  endtask

  // Let at least one overflow pass, then check channel 0 drive state.
  task automatic settle_oe(input logic [1:0] exp);
    int h;
    int e;
    logic [1:0] oe;
    repeat (200) @(posedge clock);
    measure(0, 1'b0, h, e, oe);
    check("pin enables", {30'h0, oe}, {30'h0, exp});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang costs a mismatch and ends the run the normal way.
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    int hits;
    int edges;
    logic [1:0] oe;
    logic act;
    logic [7:0] i;
    for (int k = 0; k < 64; k++) m_reg[k] = 16'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int k = 0; k < 40; k++) rd(8'(k));
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      i = (k < 8) ? IDX_CC0 + 8'(k) : IDX_DC0 + 8'(k - 8);
      seed = lfsr(seed);
      wr(i, {seed, lfsr(seed)});
      rd(i);
    end
    $display("test random registers done");
    wr(IDX_CTRL0, 16'h0004);
    wr(IDX_PER, 16'h0023);
    rd(IDX_PER);
    wr(IDX_CTRL0, 16'h0000);
    rd(IDX_PER);
    wr(IDX_CTRL0, 16'h0008);
    wr(IDX_DC0, 16'hD6FF);
    rd(IDX_DC0);
    wr(IDX_CTRL0, 16'h0000);
    rd(IDX_DC0);
    $display("test dither and resolution done");
    for (int k = 0; k < 7; k++) begin
      act = t_om[k] >= 2 && t_rc[k] != 0;
      wr(IDX_CTRL0, 16'(t_pre[k] << PRE_LSB));
      wr(IDX_CTRL1, 16'(t_rc[k] << RECIRCULATION_SIDE_BIT));
      wr(IDX_PER, 16'(t_per[k]));
      for (int c = 0; c < 2; c++) begin
        wr(IDX_CC0 + 8'(c), 16'(t_om[k] << OM_LSB | t_am[k] << AM_LSB | k % 4));
        wr(IDX_DC0 + 8'(c), 16'(t_sg[k] << SIGN_BIT | t_dty[k]));
      end
      repeat (200) @(posedge clock);
      measure(0, act, hits, edges, oe);
      check("active cycles", 32'(hits), 32'(t_dty[k] >= t_per[k] ? 120 : 120 * t_dty[k] / t_per[k]));
      check("periods", 32'(edges), 32'(t_dty[k] > 0 && t_dty[k] < t_per[k] ? 120 / (t_per[k] << t_pre[k]) : 0));
      check("enables", {30'h0, oe}, 32'(t_om[k] == 0 ? 2 : t_om[k] == 1 ? 1 : 3));
      $display("test pwm case %0d done", k);
    end
    // Quiet frames first, so the outputs are idle when the pins let go.
    for (int c = 0; c < 2; c++) wr(IDX_DC0 + 8'(c), 16'h0000);
    repeat (100) @(posedge clock);
    wr(IDX_PER, 16'h0000);
    settle_oe(2'b00);
    wr(IDX_PER, 16'h000A);
    settle_oe(2'b11);
    wr(IDX_CTRL0, 16'h0004);
    wr(IDX_PER, 16'h0001);
    rd(IDX_PER);
    settle_oe(2'b00);
    wr(IDX_CTRL0, 16'h0000);
    wr(IDX_PER, 16'h000A);
    settle_oe(2'b11);
    for (int c = 0; c < 2; c++) wr(IDX_DC0 + 8'(c), 16'h0000);
    repeat (100) @(posedge clock);
    wr(IDX_CC0, 16'h0080);
    settle_oe(2'b00);
    $display("test pin release done");
    give_verdict();
  end
endmodule
